// ### design/host_link_char_uart_map.vh
// Register map, field positions, reset values and sizes of the host link character port
`ifndef HOST_LINK_CHAR_UART_MAP_VH
`define HOST_LINK_CHAR_UART_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_CHAR_DATA_PORT      32'hFF201000
`define ADDR_UART_CONTROL_STATUS 32'hFF201004
`define ADDR_EVT_STATUS          32'hFF201008
`define ADDR_EVT_CLEAR           32'hFF20100C
`define ADDR_EVT_ENABLE          32'hFF201010

// ****************************************************************
// Field positions
// ****************************************************************
`define COUNT_MSB             31
`define COUNT_LSB             16
`define RX_VALID_BIT          15
`define CHAR_MSB              7
`define CHAR_LSB              0
`define RX_IRQ_ENABLE_BIT     0
`define TX_IRQ_ENABLE_BIT     1
`define RX_IRQ_PENDING_BIT    8
`define TX_IRQ_PENDING_BIT    9
`define HOST_TOUCHED_BIT      10
`define EVT_HOST_TOUCH_BIT    0
`define EVT_RX_DROP_BIT       1
`define EVT_TX_DROP_BIT       2
`define EVT_WIDTH             3

// ****************************************************************
// Sizes, thresholds and reset values
// ****************************************************************
`define FIFO_DEPTH            7'h40
`define FIFO_AW               6
`define IRQ_THRESHOLD         7'h07
`define RST_ENABLES           2'h0
`define RST_HOST_TOUCHED      1'h0
`define RST_EVT               3'h0

`endif

// ### design/char_fifo.v
// Sixty-four entry byte FIFO with occupancy count
`include "host_link_char_uart_map.vh"

module char_fifo (
    input  wire       clk,
    input  wire       rst,
    input  wire       push,
    input  wire [7:0] push_data,
    input  wire       pop,
    output wire [7:0] head_data,
    output wire       full,
    output wire       empty,
    output wire [6:0] count
);

    reg [7:0]             mem [0:63];
    reg [`FIFO_AW-1:0]    wr_ptr_q;
    reg [`FIFO_AW-1:0]    rd_ptr_q;
    reg [6:0]             count_q;
    wire                  do_push;
    wire                  do_pop;

    assign full      = (count_q == `FIFO_DEPTH);
    assign empty     = (count_q == 7'h00);
    assign count     = count_q;
    assign head_data = mem[rd_ptr_q];
    // A push while full is dropped; stored contents stay put
    assign do_push   = push & ~full;
    assign do_pop    = pop & ~empty;

    // ****************************************************************
    // Storage
    // ****************************************************************
    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= push_data;
        end
    end

    // ****************************************************************
    // Pointers and count
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= 6'h00;
            rd_ptr_q <= 6'h00;
            count_q  <= 7'h00;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 6'h01;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 6'h01;
            end
            if (do_push & ~do_pop) begin
                count_q <= count_q + 7'h01;
            end else if (do_pop & ~do_push) begin
                count_q <= count_q - 7'h01;
            end
        end
    end

endmodule // char_fifo

// ### design/host_link_char_uart.v
// Character port between a host link and processor software, with APB registers
//
// Behaviour
// - Processor sees a 32-bit data register and a control register one word above.
// - Bytes flow host to processor and processor to host.
// - Host characters enter a sixty-four entry receive FIFO.
// - Receive count is shown in data register bits 31 to 16.
// - A host character arriving with receive FIFO full is discarded.
// - With receive data present, bit 15 valid is one and count shows the bytes left after this one.
// - Data read returns head byte in bits 7..0, pops it, shows decremented count.
// - Data read with empty receive FIFO returns valid zero and byte zero.
// - Bytes for the host wait in a sixty-four entry transmit FIFO.
// - Data register write pushes bits 7..0 into the transmit FIFO.
// - Data register write never touches the receive FIFO or its count.
// - Free transmit entries are shown in control register bits 31 to 16.
// - A write while the transmit FIFO is full is dropped.
// - Host access sets control bit 10, held until software clears it.
// - Enabled interrupts request while receive count or transmit space exceeds seven.
// - Pending bits show the conditions and fall when their cause goes away.
`include "host_link_char_uart_map.vh"

module host_link_char_uart (
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // Host link side
    input  wire        host_clk,
    input  wire        host_wr_en,
    input  wire [7:0]  host_wr_data,
    input  wire        host_rd_en,
    output reg  [7:0]  host_rd_data,
    output reg         host_rd_valid,
    // Interrupt
    output wire        irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [1:0]              irq_en_q;
    reg                     host_touched_q;
    reg  [`EVT_WIDTH-1:0]   evt_status_q;
    reg  [`EVT_WIDTH-1:0]   evt_enable_q;
    reg                     pop_ok_q;

    reg                     hclk_s1;
    reg                     hclk_s2;
    reg                     hclk_s3;
    reg                     hwr_s1;
    reg                     hwr_s2;
    reg                     hrd_s1;
    reg                     hrd_s2;
    reg  [7:0]              hdat_s1;
    reg  [7:0]              hdat_s2;

    wire                    host_edge;
    wire                    host_push;
    wire                    host_pop;
    wire                    host_touch;

    wire                    setup_ph;
    wire                    access_ph;
    wire                    wr_acc;
    wire                    rd_acc;
    wire                    sel_data;
    wire                    sel_ctrl;
    wire                    sel_status;
    wire                    sel_clear;
    wire                    sel_enable;
    wire                    addr_ok;

    wire                    rx_full;
    wire                    rx_empty;
    wire [6:0]              rx_count;
    wire [7:0]              rx_head;
    wire                    rx_pop;

    wire                    tx_full;
    wire                    tx_empty;
    wire [6:0]              tx_count;
    wire [7:0]              tx_head;
    wire                    tx_push;
    wire [6:0]              tx_space;

    wire                    rx_irq_pending;
    wire                    tx_irq_pending;
    wire [`EVT_WIDTH-1:0]   evt_set;
    wire [`EVT_WIDTH-1:0]   evt_clr;

    reg  [31:0]             rd_mux;
    reg  [6:0]              rx_count_after;

    // ****************************************************************
    // Host link synchronisers
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            hclk_s1 <= 1'h0;
            hclk_s2 <= 1'h0;
            hclk_s3 <= 1'h0;
            hwr_s1  <= 1'h0;
            hwr_s2  <= 1'h0;
            hrd_s1  <= 1'h0;
            hrd_s2  <= 1'h0;
            hdat_s1 <= 8'h00;
            hdat_s2 <= 8'h00;
        end else begin
            hclk_s1 <= host_clk;
            hclk_s2 <= hclk_s1;
            hclk_s3 <= hclk_s2;
            hwr_s1  <= host_wr_en;
            hwr_s2  <= hwr_s1;
            hrd_s1  <= host_rd_en;
            hrd_s2  <= hrd_s1;
            hdat_s1 <= host_wr_data;
            hdat_s2 <= hdat_s1;
        end
    end

    // Rising edge of the host clock, seen after synchronisation
    assign host_edge  = hclk_s2 & ~hclk_s3;
    assign host_push  = host_edge & hwr_s2;
    assign host_pop   = host_edge & hrd_s2 & ~tx_empty;
    assign host_touch = host_edge & (hwr_s2 | hrd_s2);

    // ****************************************************************
    // Host side transmit output
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            host_rd_data  <= 8'h00;
            host_rd_valid <= 1'h0;
        end else if (host_edge) begin
            host_rd_valid <= host_pop;
            if (host_pop) begin
                host_rd_data <= tx_head;
            end
        end
    end

    // ****************************************************************
    // FIFOs
    // ****************************************************************
    // Host bytes enter here; overflow is dropped inside the FIFO
    char_fifo u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .push      (host_push),
        .push_data (hdat_s2),
        .pop       (rx_pop),
        .head_data (rx_head),
        .full      (rx_full),
        .empty     (rx_empty),
        .count     (rx_count)
    );

    // Processor bytes wait here for the host
    char_fifo u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .push      (tx_push),
        .push_data (pwdata[`CHAR_MSB:`CHAR_LSB]),
        .pop       (host_pop),
        .head_data (tx_head),
        .full      (tx_full),
        .empty     (tx_empty),
        .count     (tx_count)
    );

    assign tx_space = `FIFO_DEPTH - tx_count;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign setup_ph   = psel & ~penable;
    assign access_ph  = psel & penable;
    assign pready     = 1'h1;
    assign sel_data   = (paddr == `ADDR_CHAR_DATA_PORT);
    assign sel_ctrl   = (paddr == `ADDR_UART_CONTROL_STATUS);
    assign sel_status = (paddr == `ADDR_EVT_STATUS);
    assign sel_clear  = (paddr == `ADDR_EVT_CLEAR);
    assign sel_enable = (paddr == `ADDR_EVT_ENABLE);
    assign addr_ok    = sel_data | sel_ctrl | sel_status | sel_clear | sel_enable;
    assign wr_acc     = access_ph & pwrite & addr_ok;
    assign rd_acc     = access_ph & ~pwrite & addr_ok;

    // Writes to the data port only feed the transmit FIFO
    assign tx_push    = wr_acc & sel_data;
    // Pop only when the setup phase saw a valid byte
    assign rx_pop     = rd_acc & sel_data & pop_ok_q;

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @* begin
        rx_count_after = rx_empty ? 7'h00 : (rx_count - 7'h01);
        rd_mux = 32'h00000000;
        if (sel_data) begin
            rd_mux[`COUNT_MSB:`COUNT_LSB] = {9'h000, rx_count_after};
            rd_mux[`RX_VALID_BIT]         = ~rx_empty;
            rd_mux[`CHAR_MSB:`CHAR_LSB]   = rx_empty ? 8'h00 : rx_head;
        end else if (sel_ctrl) begin
            rd_mux[`COUNT_MSB:`COUNT_LSB]  = {9'h000, tx_space};
            rd_mux[`HOST_TOUCHED_BIT]      = host_touched_q;
            rd_mux[`TX_IRQ_PENDING_BIT]    = tx_irq_pending;
            rd_mux[`RX_IRQ_PENDING_BIT]    = rx_irq_pending;
            rd_mux[`TX_IRQ_ENABLE_BIT]     = irq_en_q[1];
            rd_mux[`RX_IRQ_ENABLE_BIT]     = irq_en_q[0];
        end else if (sel_status) begin
            rd_mux[`EVT_WIDTH-1:0] = evt_status_q;
        end else if (sel_enable) begin
            rd_mux[`EVT_WIDTH-1:0] = evt_enable_q;
        end
    end

    // Read data is captured in the setup phase and held for the access phase
    always @(posedge clk) begin
        if (rst) begin
            prdata   <= 32'h00000000;
            pslverr  <= 1'h0;
            pop_ok_q <= 1'h0;
        end else if (setup_ph) begin
            prdata   <= pwrite ? 32'h00000000 : rd_mux;
            pslverr  <= ~addr_ok;
            pop_ok_q <= ~pwrite & sel_data & ~rx_empty;
        end else if (access_ph) begin
            pop_ok_q <= 1'h0;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            irq_en_q       <= `RST_ENABLES;
            host_touched_q <= `RST_HOST_TOUCHED;
        end else begin
            if (wr_acc & sel_ctrl) begin
                irq_en_q[0] <= pwdata[`RX_IRQ_ENABLE_BIT];
                irq_en_q[1] <= pwdata[`TX_IRQ_ENABLE_BIT];
            end
            // Host access sets, write one clears, set wins
            if (host_touch) begin
                host_touched_q <= 1'h1;
            end else if (wr_acc & sel_ctrl & pwdata[`HOST_TOUCHED_BIT]) begin
                host_touched_q <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // FIFO level interrupts
    // ****************************************************************
    assign rx_irq_pending = irq_en_q[0] & (rx_count > `IRQ_THRESHOLD);
    assign tx_irq_pending = irq_en_q[1] & (tx_space > `IRQ_THRESHOLD);

    // ****************************************************************
    // Event status, clear and enable
    // ****************************************************************
    assign evt_set[`EVT_HOST_TOUCH_BIT] = host_touch;
    assign evt_set[`EVT_RX_DROP_BIT]    = host_push & rx_full;
    assign evt_set[`EVT_TX_DROP_BIT]    = tx_push & tx_full;
    assign evt_clr = (wr_acc & sel_clear) ? pwdata[`EVT_WIDTH-1:0] : `RST_EVT;

    genvar gi;
    generate
        for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1) begin : g_evt
            always @(posedge clk) begin
                if (rst) begin
                    evt_status_q[gi] <= 1'h0;
                end else if (evt_set[gi]) begin
                    evt_status_q[gi] <= 1'h1;
                end else if (evt_clr[gi]) begin
                    evt_status_q[gi] <= 1'h0;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (rst) begin
            evt_enable_q <= `RST_EVT;
        end else if (wr_acc & sel_enable) begin
            evt_enable_q <= pwdata[`EVT_WIDTH-1:0];
        end
    end

    // One level request for the processor
    assign irq = rx_irq_pending | tx_irq_pending | (|(evt_status_q & evt_enable_q));

endmodule // host_link_char_uart

// ### verif/host_link_char_uart_assertions.sv
// Port-level assertions for the host link character port
`include "host_link_char_uart_map.vh"

module host_link_char_uart_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  host_rd_data,
    input wire logic        host_rd_valid,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire setup  = psel && !penable;
    wire rd_dat = setup && !pwrite && paddr == `ADDR_CHAR_DATA_PORT;
    wire rd_ctl = setup && !pwrite && paddr == `ADDR_UART_CONTROL_STATUS;
    wire mapped = paddr inside {`ADDR_CHAR_DATA_PORT, `ADDR_UART_CONTROL_STATUS,
                  `ADDR_EVT_STATUS, `ADDR_EVT_CLEAR, `ADDR_EVT_ENABLE};

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_ready; pready; endproperty
    property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h0; endproperty
    property p_reset;
        $fell(rst) |-> !irq && !pslverr && !host_rd_valid && prdata == 32'h0
            && host_rd_data == 8'h0;
    endproperty
    property p_empty; rd_dat |=> (!prdata[15] |-> prdata == 32'h0); endproperty
    property p_count; rd_dat |=> prdata[31:16] <= 16'h3F && prdata[14:8] == 7'h0; endproperty
    property p_ctl_fields;
        rd_ctl |=> prdata[31:16] <= 16'h40 && prdata[15:11] == 5'h0 && prdata[7:2] == 6'h0;
    endproperty
    property p_pend_en; rd_ctl |=> (!prdata[8] || prdata[0]) && (!prdata[9] || prdata[1]);
    endproperty
    property p_tx_pend; rd_ctl |=> prdata[9] == (prdata[1] && prdata[31:16] > 16'h7);
    endproperty
    property p_hold; psel && penable |=> $stable(prdata); endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    a_empty: assert property (p_empty) else $error("empty read not zero");
    a_count: assert property (p_count) else $error("rx count out of range");
    a_ctl_fields: assert property (p_ctl_fields) else $error("control fields bad");
    a_pend_en: assert property (p_pend_en) else $error("pending without enable");
    a_tx_pend: assert property (p_tx_pend) else $error("tx pending wrong");
    a_hold: assert property (p_hold) else $error("read data moved");

    c_unmapped: cover property (setup && !mapped);
    c_valid: cover property (rd_dat ##1 prdata[15]);
    c_tx_pend: cover property (rd_ctl ##1 prdata[9]);
endmodule // host_link_char_uart_checker

bind host_link_char_uart host_link_char_uart_checker chk_u (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .irq(irq));

// ### verif/host_link_model.sv
// Behavioural host computer at the far end of the link
module host_link_model (
    output logic            host_clk,
    output logic            host_wr_en,
    output logic [7:0]      host_wr_data,
    output logic            host_rd_en,
    input  wire logic [7:0] host_rd_data,
    input  wire logic       host_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Link clock stands low between frames
    // ****************************************************************
    initial begin
        host_clk = 1'b0;
        host_wr_en = 1'b0;
        host_wr_data = 8'hFF;
        host_rd_en = 1'b0;
    end

    // Offer one byte; data line shows the inverse once released
    // Link edges sit 3 ns off the system clock grid
    task automatic send(input logic [7:0] d, input int gap);
        #3;
        host_wr_en = 1'b1;
        host_wr_data = d;
        #40 host_clk = 1'b1;
        #40 host_clk = 1'b0;
        host_wr_en = 1'b0;
        host_wr_data = ~d;
        #(37 + gap);
    endtask

    // Ask for one byte and take it at the next rising edge
    task automatic fetch(output logic [7:0] d, output logic v);
        #3;
        host_rd_en = 1'b1;
        #40 host_clk = 1'b1;
        #40 host_clk = 1'b0;
        host_rd_en = 1'b0;
        #40 host_clk = 1'b1;
        d = host_rd_data;
        v = host_rd_valid;
        #40 host_clk = 1'b0;
        #37;
    endtask
endmodule // host_link_model

// ### verif/host_link_char_uart_tb.sv
// Self-checking bench for the host link character port
`include "host_link_char_uart_map.vh"

module host_link_char_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         host_clk;
    wire         host_wr_en;
    wire  [7:0]  host_wr_data;
    wire         host_rd_en;
    wire  [7:0]  host_rd_data;
    wire         host_rd_valid;
    wire         irq;
    int          failures;
    int          checks;
    logic [31:0] r;
    logic        err;
    logic [7:0]  hb;
    logic        hv;

    host_link_char_uart dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_clk(host_clk), .host_wr_en(host_wr_en),
        .host_wr_data(host_wr_data), .host_rd_en(host_rd_en), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid), .irq(irq));
    host_link_model host_u (.host_clk(host_clk), .host_wr_en(host_wr_en),
        .host_wr_data(host_wr_data), .host_rd_en(host_rd_en), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid));

    always #5 clk = ~clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test();
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            stop_test();
        end else begin
            r = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input logic [31:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    function automatic logic [31:0] ctl(input logic [15:0] sp, input logic fl, tp, rp,
                                        input logic [1:0] en);
        return {sp, 5'h0, fl, tp, rp, 6'h0, en};
    endfunction

    function automatic logic [31:0] dat(input logic [15:0] c, input logic [7:0] b);
        return {c, 1'b1, 7'h0, b};
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic s_reset();
        rd(`ADDR_CHAR_DATA_PORT);
        check("data_empty", 32'h0, r);
        rd(`ADDR_UART_CONTROL_STATUS);
        check("ctl_reset", ctl(16'h40, 1'b0, 1'b0, 1'b0, 2'h0), r);
        rd(32'hFF201014);
        check("unmapped_err", 32'h1, {31'h0, err});
        check("irq_reset", 32'h0, {31'h0, irq});
    endtask

    task automatic s_irq();
        wr(`ADDR_UART_CONTROL_STATUS, 32'h3);
        rd(`ADDR_UART_CONTROL_STATUS);
        check("ctl_tx_pend", ctl(16'h40, 1'b0, 1'b1, 1'b0, 2'h3), r);
        check("irq_tx", 32'h1, {31'h0, irq});
        wr(`ADDR_UART_CONTROL_STATUS, 32'h0);
        @(posedge clk);
        check("irq_off", 32'h0, {31'h0, irq});
    endtask

    task automatic s_rx();
        wr(`ADDR_UART_CONTROL_STATUS, 32'h1);
        for (int i = 0; i < 10; i++) host_u.send(8'hA0 + i[7:0], i * 10);
        repeat (5) @(posedge clk);
        check("irq_rx", 32'h1, {31'h0, irq});
        rd(`ADDR_UART_CONTROL_STATUS);
        check("ctl_rx", ctl(16'h40, 1'b1, 1'b0, 1'b1, 2'h1), r);
        wr(`ADDR_UART_CONTROL_STATUS, 32'h1);
        rd(`ADDR_UART_CONTROL_STATUS);
        check("flag_kept", ctl(16'h40, 1'b1, 1'b0, 1'b1, 2'h1), r);
        wr(`ADDR_UART_CONTROL_STATUS, 32'h401);
        rd(`ADDR_UART_CONTROL_STATUS);
        check("flag_clear", ctl(16'h40, 1'b0, 1'b0, 1'b1, 2'h1), r);
        for (int i = 0; i < 10; i++) begin
            rd(`ADDR_CHAR_DATA_PORT);
            check("rx_read", dat(16'(9 - i), 8'hA0 + i[7:0]), r);
            if (i == 1 || i == 2) begin
                rd(`ADDR_UART_CONTROL_STATUS);
                check("rx_pend", {31'h0, i == 1}, {31'h0, r[8]});
            end
        end
        rd(`ADDR_CHAR_DATA_PORT);
        check("rx_drained", 32'h0, r);
        check("irq_drained", 32'h0, {31'h0, irq});
    endtask

    task automatic s_rx_full();
        wr(`ADDR_UART_CONTROL_STATUS, 32'h0);
        for (int i = 0; i < 65; i++) host_u.send(i[7:0], 0);
        repeat (5) @(posedge clk);
        wr(`ADDR_CHAR_DATA_PORT, 32'h5A);
        rd(`ADDR_CHAR_DATA_PORT);
        check("rx_full_head", dat(16'h3F, 8'h00), r);
        rd(`ADDR_EVT_STATUS);
        check("evt_drop", 32'h3, r);
        wr(`ADDR_EVT_ENABLE, 32'h2);
        rd(`ADDR_EVT_ENABLE);
        check("evt_enable", 32'h2, r);
        @(posedge clk);
        check("irq_evt", 32'h1, {31'h0, irq});
        wr(`ADDR_EVT_CLEAR, 32'h3);
        rd(`ADDR_EVT_STATUS);
        check("evt_clear", 32'h0, r);
        check("irq_evt_off", 32'h0, {31'h0, irq});
        for (int i = 0; i < 63; i++) begin
            rd(`ADDR_CHAR_DATA_PORT);
            check("rx_full_read", dat(16'(62 - i), i[7:0] + 8'h1), r);
        end
        rd(`ADDR_CHAR_DATA_PORT);
        check("rx_full_drop", 32'h0, r);
    endtask

    task automatic s_tx();
        for (int i = 0; i < 63; i++) wr(`ADDR_CHAR_DATA_PORT, 32'h10 + i);
        rd(`ADDR_UART_CONTROL_STATUS);
        check("tx_full_space", ctl(16'h0, 1'b1, 1'b0, 1'b0, 2'h0), r);
        wr(`ADDR_CHAR_DATA_PORT, 32'hEE);
        rd(`ADDR_EVT_STATUS);
        check("evt_tx_drop", 32'h4, r);
        for (int i = 0; i < 64; i++) begin
            host_u.fetch(hb, hv);
            check("tx_byte", {23'h0, 1'b1, i == 0 ? 8'h5A : 8'h0F + i[7:0]},
                  {23'h0, hv, hb});
        end
        host_u.fetch(hb, hv);
        check("tx_empty", 32'h0, {31'h0, hv});
        rd(`ADDR_UART_CONTROL_STATUS);
        check("tx_space_back", ctl(16'h40, 1'b1, 1'b0, 1'b0, 2'h0), r);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        failures = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        s_reset();
        s_irq();
        s_rx();
        s_rx_full();
        s_tx();
        stop_test();
    end
endmodule // host_link_char_uart_tb
